/* rtl/tcb_chan.sv */
`timescale 1ns/1ps
`default_nettype none

module tcb_chan (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Configuration and software access
	input wire logic [2:0] mode,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wdata,
	// Time bases
	input wire logic [15:0] count,
	input wire logic count_tick,
	input wire logic [7:0] pwm_count,
	input wire logic pwm_restart,
	// Pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	// Results
	output logic [15:0] value,
	output logic chan_event,
	output logic special_event
);

	logic pin_prev_reg;
	logic capture_hit;
	logic compare_hit;
	logic is_compare;

	assign is_compare = (mode == tcb_pkg::MODE_COMPARE_TOGGLE) ||
		(mode == tcb_pkg::MODE_COMPARE_SPECIAL);
	assign capture_hit =
		((mode == tcb_pkg::MODE_CAPTURE_RISE) && pin_in && !pin_prev_reg) ||
		((mode == tcb_pkg::MODE_CAPTURE_FALL) && !pin_in && pin_prev_reg);
	assign compare_hit = is_compare && count_tick && (value == count);
	assign chan_event = capture_hit || compare_hit;
	assign special_event = compare_hit &&
		(mode == tcb_pkg::MODE_COMPARE_SPECIAL);
	assign pin_oe = is_compare || (mode == tcb_pkg::MODE_PWM);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_in;
		end
	end

	// Capture copies the shared count as it stands, cleared or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= tcb_pkg::RST_COUNT;
		end else if (capture_hit) begin
			value <= count;
		end else begin
			if (wr_low) begin
				value[7:0] <= wdata;
			end
			if (wr_high) begin
				value[15:8] <= wdata;
			end
		end
	end

	// Toggle compare flips the pin; PWM rises at each period restart unless its duty byte is zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b0;
		end else if (mode == tcb_pkg::MODE_PWM) begin
			if (pwm_restart) begin
				pin_out <= (value[7:0] != 8'h00);
			end else if (pwm_count == value[7:0]) begin
				pin_out <= 1'b0;
			end
		end else if (compare_hit &&
			(mode == tcb_pkg::MODE_COMPARE_TOGGLE)) begin
			pin_out <= !pin_out;
		end
	end

endmodule : tcb_chan

`default_nettype wire

/* rtl/tcb_pkg.sv */
package tcb_pkg;

	////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
	localparam logic [7:0] ADDR_COUNTER_CTRL = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_PERIPH_ENABLES = 8'h10;
	localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_CHAN1_LOW = 8'h18;
	localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h1C;
	localparam logic [7:0] ADDR_CHAN1_MODE = 8'h20;
	localparam logic [7:0] ADDR_CHAN2_LOW = 8'h24;
	localparam logic [7:0] ADDR_CHAN2_HIGH = 8'h28;
	localparam logic [7:0] ADDR_CHAN2_MODE = 8'h2C;
	localparam logic [7:0] ADDR_ALT_PIN_SELECT = 8'h30;
	localparam logic [7:0] ADDR_PERIOD_CTRL = 8'h34;
	localparam logic [7:0] ADDR_PERIOD_VALUE = 8'h38;
	localparam logic [7:0] ADDR_PERIOD_COUNT = 8'h3C;

	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTL_RUN = 0;
	localparam int CTL_SYNC_BYPASS = 1;
	localparam int CTL_CLOCK_SELECT = 2;
	localparam int CTL_OSC_ENABLE = 3;
	localparam int IRQ_GLOBAL = 7;
	localparam int IRQ_PERIPH = 6;
	localparam int FLG_ROLLOVER = 0;
	localparam int FLG_PERIOD = 1;
	localparam int FLG_CHAN1 = 2;
	localparam int FLG_CHAN2 = 3;
	localparam int ALT_CHAN2 = 0;
	localparam int ALT_SLAVE_SELECT = 1;
	localparam int PTC_POST_LSB = 3;
	localparam int PTC_RUN = 2;
	localparam int PTC_PRE_LSB = 0;

	////////////////////////////////////////////////////////////////////
	// Reset values and constants
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] ISR_VECTOR = 16'h0004;
	localparam logic [3:0] PRE_LIMIT_1 = 4'h0;
	localparam logic [3:0] PRE_LIMIT_4 = 4'h3;
	localparam logic [3:0] PRE_LIMIT_16 = 4'hF;

	////////////////////////////////////////////////////////////////////
	// Channel mode codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_CAPTURE_RISE = 3'h1;
	localparam logic [2:0] MODE_CAPTURE_FALL = 3'h2;
	localparam logic [2:0] MODE_COMPARE_TOGGLE = 3'h3;
	localparam logic [2:0] MODE_COMPARE_SPECIAL = 3'h4;
	localparam logic [2:0] MODE_PWM = 3'h5;

endpackage : tcb_pkg

/* rtl/tcb_postscale.sv */
`timescale 1ns/1ps
`default_nettype none

module tcb_postscale #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events
	input wire logic evt_in,
	input wire logic [W-1:0] ratio,
	output logic evt_out
);

	logic [W-1:0] cnt_reg;

	// Passes one event in ratio+1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (evt_in) begin
			if (cnt_reg >= ratio) begin
				cnt_reg <= '0;
			end else begin
				cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign evt_out = evt_in && (cnt_reg >= ratio);

endmodule : tcb_postscale

`default_nettype wire

/* rtl/tcb_timebase.sv */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Counter wraps FFFFh to 0000h, sets flag
// - Rollover interrupt needs all four enables
// - Rollover flag holds until written zero
// - Counts asleep only in asynchronous external mode
// - Overflow while asleep wakes the core
// - Wake with global enable branches to 0004h
// - Capture/compare use counter, PWM period timer
// - Capture copies count into channel register
// - Compare match of register and count
// - Special event trigger clears the count
// - Special clear sets no rollover flag
// - Counter write beats a coincident clear
// - Trigger clear shows in other's capture
// - PWM channels share period, aligned edges
// - Pin-select bit 0 steers channel two
// - Postscaler code plus one divides events
module tcb_timebase (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Counter clock pin and core state
	input wire logic ext_clk_in,
	input wire logic sleep_in,
	// Channel pins
	input wire logic chan1_pin_in,
	output logic chan1_pin_out,
	output logic chan1_pin_oe,
	input wire logic chan2_default_in,
	output logic chan2_default_out,
	output logic chan2_default_oe,
	input wire logic chan2_alt_in,
	output logic chan2_alt_out,
	output logic chan2_alt_oe,
	output logic slave_select_alt,
	// Core interrupt signals
	output logic irq_req,
	output logic wake_req,
	output logic isr_branch,
	output logic [15:0] isr_vector
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	logic [15:0] count_reg;
	logic [7:0] counter_ctrl_reg;
	logic [7:0] irq_control_reg;
	logic [7:0] periph_enables_reg;
	logic [3:0] periph_flags_reg;
	logic [2:0] chan1_mode_reg;
	logic [2:0] chan2_mode_reg;
	logic [1:0] alt_pin_select_reg;
	logic [6:0] period_ctrl_reg;
	logic [7:0] period_value_reg;
	logic [7:0] period_count_reg;
	logic [3:0] prescale_reg;
	logic ext_prev_reg;
	logic [31:0] prdata_next;
	logic addr_ok;

	logic wr_en;
	logic wr_count_low;
	logic wr_count_high;
	logic wr_flags;
	logic [7:0] wdata;

	logic run;
	logic sync_bypass;
	logic clock_select;
	logic async_mode;
	logic count_tick;
	logic special_clear;
	logic rollover;
	logic [3:0] flag_set;

	logic [15:0] chan1_value;
	logic [15:0] chan2_value;
	logic chan1_event;
	logic chan2_event;
	logic chan1_special;
	logic chan2_special;
	logic chan2_pin_in;
	logic chan2_pin_out;
	logic chan2_pin_oe;

	logic period_run;
	logic [3:0] pre_limit;
	logic pre_tick;
	logic period_match;
	logic period_event;
	logic [7:0] pwm_count;

	logic irq_pending;

	////////////////////////////////////////////////////////////////////
	// APB access

	assign wr_en = psel && penable && pwrite;
	assign wdata = pwdata[7:0];
	assign wr_count_low = wr_en && (paddr == tcb_pkg::ADDR_COUNT_LOW);
	assign wr_count_high = wr_en && (paddr == tcb_pkg::ADDR_COUNT_HIGH);
	assign wr_flags = wr_en && (paddr == tcb_pkg::ADDR_PERIPH_FLAGS);
	assign pready = 1'b1;

	always_comb begin
		addr_ok = 1'b1;
		prdata_next = 32'h00000000;
		case (paddr)
			tcb_pkg::ADDR_COUNT_LOW: begin
				prdata_next[7:0] = count_reg[7:0];
			end
			tcb_pkg::ADDR_COUNT_HIGH: begin
				prdata_next[7:0] = count_reg[15:8];
			end
			tcb_pkg::ADDR_COUNTER_CTRL: begin
				prdata_next[7:0] = counter_ctrl_reg;
			end
			tcb_pkg::ADDR_IRQ_CONTROL: begin
				prdata_next[7:0] = irq_control_reg;
			end
			tcb_pkg::ADDR_PERIPH_ENABLES: begin
				prdata_next[7:0] = periph_enables_reg;
			end
			tcb_pkg::ADDR_PERIPH_FLAGS: begin
				prdata_next[3:0] = periph_flags_reg;
			end
			tcb_pkg::ADDR_CHAN1_LOW: begin
				prdata_next[7:0] = chan1_value[7:0];
			end
			tcb_pkg::ADDR_CHAN1_HIGH: begin
				prdata_next[7:0] = chan1_value[15:8];
			end
			tcb_pkg::ADDR_CHAN1_MODE: begin
				prdata_next[2:0] = chan1_mode_reg;
			end
			tcb_pkg::ADDR_CHAN2_LOW: begin
				prdata_next[7:0] = chan2_value[7:0];
			end
			tcb_pkg::ADDR_CHAN2_HIGH: begin
				prdata_next[7:0] = chan2_value[15:8];
			end
			tcb_pkg::ADDR_CHAN2_MODE: begin
				prdata_next[2:0] = chan2_mode_reg;
			end
			tcb_pkg::ADDR_ALT_PIN_SELECT: begin
				prdata_next[1:0] = alt_pin_select_reg;
			end
			tcb_pkg::ADDR_PERIOD_CTRL: begin
				prdata_next[6:0] = period_ctrl_reg;
			end
			tcb_pkg::ADDR_PERIOD_VALUE: begin
				prdata_next[7:0] = period_value_reg;
			end
			tcb_pkg::ADDR_PERIOD_COUNT: begin
				prdata_next[7:0] = period_count_reg;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Read data is sampled in the setup cycle and held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h00000000 : prdata_next;
		end
	end

	assign pslverr = psel && penable && !addr_ok;

	////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_ctrl_reg <= tcb_pkg::RST_BYTE;
			irq_control_reg <= tcb_pkg::RST_BYTE;
			periph_enables_reg <= tcb_pkg::RST_BYTE;
			chan1_mode_reg <= tcb_pkg::MODE_OFF;
			chan2_mode_reg <= tcb_pkg::MODE_OFF;
			alt_pin_select_reg <= 2'h0;
			period_ctrl_reg <= 7'h00;
			period_value_reg <= 8'hFF;
		end else if (wr_en) begin
			case (paddr)
				tcb_pkg::ADDR_COUNTER_CTRL: begin
					counter_ctrl_reg <= {4'h0, wdata[3:0]};
				end
				tcb_pkg::ADDR_IRQ_CONTROL: begin
					irq_control_reg <= {wdata[7:6], 6'h00};
				end
				tcb_pkg::ADDR_PERIPH_ENABLES: begin
					periph_enables_reg <= {4'h0, wdata[3:0]};
				end
				tcb_pkg::ADDR_CHAN1_MODE: begin
					chan1_mode_reg <= wdata[2:0];
				end
				tcb_pkg::ADDR_CHAN2_MODE: begin
					chan2_mode_reg <= wdata[2:0];
				end
				tcb_pkg::ADDR_ALT_PIN_SELECT: begin
					alt_pin_select_reg <= wdata[1:0];
				end
				tcb_pkg::ADDR_PERIOD_CTRL: begin
					period_ctrl_reg <= wdata[6:0];
				end
				tcb_pkg::ADDR_PERIOD_VALUE: begin
					period_value_reg <= wdata;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sixteen-bit counter

	assign run = counter_ctrl_reg[tcb_pkg::CTL_RUN];
	assign sync_bypass = counter_ctrl_reg[tcb_pkg::CTL_SYNC_BYPASS];
	assign clock_select = counter_ctrl_reg[tcb_pkg::CTL_CLOCK_SELECT];
	assign async_mode = clock_select && sync_bypass;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_clk_in;
		end
	end

	// Instruction clock or external rising edge; only async runs asleep
	assign count_tick = run && (!sleep_in || async_mode) &&
		(clock_select ? (ext_clk_in && !ext_prev_reg) : 1'b1);

	assign special_clear = chan1_special || chan2_special;
	assign rollover = count_tick && (count_reg == tcb_pkg::COUNT_MAX) &&
		!special_clear && !wr_count_low && !wr_count_high;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= tcb_pkg::RST_COUNT;
		end else if (wr_count_low || wr_count_high) begin
			if (wr_count_low) begin
				count_reg[7:0] <= wdata;
			end
			if (wr_count_high) begin
				count_reg[15:8] <= wdata;
			end
		end else if (special_clear) begin
			count_reg <= tcb_pkg::RST_COUNT;
		end else if (count_tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Capture/compare channels on the shared counter

	assign chan2_pin_in = alt_pin_select_reg[tcb_pkg::ALT_CHAN2] ?
		chan2_alt_in : chan2_default_in;

	tcb_chan u_chan1 (
		.pclk(pclk),
		.presetn(presetn),
		.mode(chan1_mode_reg),
		.wr_low(wr_en && (paddr == tcb_pkg::ADDR_CHAN1_LOW)),
		.wr_high(wr_en && (paddr == tcb_pkg::ADDR_CHAN1_HIGH)),
		.wdata(wdata),
		.count(count_reg),
		.count_tick(count_tick),
		.pwm_count(pwm_count),
		.pwm_restart(period_match),
		.pin_in(chan1_pin_in),
		.pin_out(chan1_pin_out),
		.pin_oe(chan1_pin_oe),
		.value(chan1_value),
		.chan_event(chan1_event),
		.special_event(chan1_special)
	);

	tcb_chan u_chan2 (
		.pclk(pclk),
		.presetn(presetn),
		.mode(chan2_mode_reg),
		.wr_low(wr_en && (paddr == tcb_pkg::ADDR_CHAN2_LOW)),
		.wr_high(wr_en && (paddr == tcb_pkg::ADDR_CHAN2_HIGH)),
		.wdata(wdata),
		.count(count_reg),
		.count_tick(count_tick),
		.pwm_count(pwm_count),
		.pwm_restart(period_match),
		.pin_in(chan2_pin_in),
		.pin_out(chan2_pin_out),
		.pin_oe(chan2_pin_oe),
		.value(chan2_value),
		.chan_event(chan2_event),
		.special_event(chan2_special)
	);

	// Only the selected pin is driven
	assign chan2_default_out = chan2_pin_out;
	assign chan2_alt_out = chan2_pin_out;
	assign chan2_default_oe = chan2_pin_oe &&
		!alt_pin_select_reg[tcb_pkg::ALT_CHAN2];
	assign chan2_alt_oe = chan2_pin_oe &&
		alt_pin_select_reg[tcb_pkg::ALT_CHAN2];
	assign slave_select_alt = alt_pin_select_reg[tcb_pkg::ALT_SLAVE_SELECT];

	////////////////////////////////////////////////////////////////////
	// Eight-bit period timer

	assign period_run = period_ctrl_reg[tcb_pkg::PTC_RUN] && !sleep_in;
	assign pwm_count = period_count_reg;

	always_comb begin
		case (period_ctrl_reg[tcb_pkg::PTC_PRE_LSB +: 2])
			2'h0: begin
				pre_limit = tcb_pkg::PRE_LIMIT_1;
			end
			2'h1: begin
				pre_limit = tcb_pkg::PRE_LIMIT_4;
			end
			default: begin
				pre_limit = tcb_pkg::PRE_LIMIT_16;
			end
		endcase
	end

	assign pre_tick = period_run && (prescale_reg >= pre_limit);
	assign period_match = pre_tick && (period_count_reg == period_value_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_reg <= 4'h0;
		end else if (!period_run || pre_tick) begin
			prescale_reg <= 4'h0;
		end else begin
			prescale_reg <= prescale_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_count_reg <= 8'h00;
		end else if (wr_en && (paddr == tcb_pkg::ADDR_PERIOD_COUNT)) begin
			period_count_reg <= wdata;
		end else if (period_match) begin
			period_count_reg <= 8'h00;
		end else if (pre_tick) begin
			period_count_reg <= period_count_reg + 8'h01;
		end
	end

	tcb_postscale #(
		.W(4)
	) u_postscale (
		.pclk(pclk),
		.presetn(presetn),
		.evt_in(period_match),
		.ratio(period_ctrl_reg[tcb_pkg::PTC_POST_LSB +: 4]),
		.evt_out(period_event)
	);

	////////////////////////////////////////////////////////////////////
	// Flags, interrupt request and wake

	always_comb begin
		flag_set = 4'h0;
		flag_set[tcb_pkg::FLG_ROLLOVER] = rollover;
		flag_set[tcb_pkg::FLG_PERIOD] = period_event;
		flag_set[tcb_pkg::FLG_CHAN1] = chan1_event;
		flag_set[tcb_pkg::FLG_CHAN2] = chan2_event;
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_flags_reg <= 4'h0;
		end else if (wr_flags) begin
			periph_flags_reg <= wdata[3:0] | flag_set;
		end else begin
			periph_flags_reg <= periph_flags_reg | flag_set;
		end
	end

	assign irq_pending = irq_control_reg[tcb_pkg::IRQ_PERIPH] &&
		(((periph_flags_reg & periph_enables_reg[3:0]) &
		4'b1110) != 4'h0 ||
		(run && periph_flags_reg[tcb_pkg::FLG_ROLLOVER] &&
		periph_enables_reg[tcb_pkg::FLG_ROLLOVER]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= irq_pending &&
				irq_control_reg[tcb_pkg::IRQ_GLOBAL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_req <= 1'b0;
			isr_branch <= 1'b0;
		end else begin
			wake_req <= sleep_in && run && async_mode &&
				periph_flags_reg[tcb_pkg::FLG_ROLLOVER] &&
				periph_enables_reg[tcb_pkg::FLG_ROLLOVER] &&
				irq_control_reg[tcb_pkg::IRQ_PERIPH];
			isr_branch <= sleep_in && run && async_mode &&
				periph_flags_reg[tcb_pkg::FLG_ROLLOVER] &&
				periph_enables_reg[tcb_pkg::FLG_ROLLOVER] &&
				irq_control_reg[tcb_pkg::IRQ_PERIPH] &&
				irq_control_reg[tcb_pkg::IRQ_GLOBAL];
		end
	end

	assign isr_vector = tcb_pkg::ISR_VECTOR;

endmodule : tcb_timebase

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct packed {
		logic [7:0] d;
		logic [7:0] m;
		logic err;
	} tcb_exp_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, lo, hi;
	logic [31:0] pwdata, prdata;
	logic ext_clk_in, sleep_in, chan1_pin_in, chan1_pin_out, chan1_pin_oe;
	logic chan2_default_in, chan2_default_out, chan2_default_oe;
	logic chan2_alt_in, chan2_alt_out, chan2_alt_oe, slave_select_alt;
	logic irq_req, wake_req, isr_branch;
	logic [15:0] isr_vector;
	tcb_exp_t exp_q[$];
	tcb_exp_t e;
	int mismatches, num_checks;

	tcb_timebase u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
		.sleep_in(sleep_in), .chan1_pin_in(chan1_pin_in),
		.chan1_pin_out(chan1_pin_out), .chan1_pin_oe(chan1_pin_oe),
		.chan2_default_in(chan2_default_in),
		.chan2_default_out(chan2_default_out),
		.chan2_default_oe(chan2_default_oe), .chan2_alt_in(chan2_alt_in),
		.chan2_alt_out(chan2_alt_out), .chan2_alt_oe(chan2_alt_oe),
		.slave_select_alt(slave_select_alt), .irq_req(irq_req),
		.wake_req(wake_req), .isr_branch(isr_branch), .isr_vector(isr_vector)
	);

	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'h1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, d, m, input logic err);
		exp_q.push_back('{d, m, err});
		apb(a, 1'h0, 8'h00);
	endtask : rd

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt

	// Pulse high then low on chan2_alt_in, chan2_default_in, chan1_pin_in
	task automatic pulse(input logic [2:0] s);
		@(posedge pclk);
		{chan2_alt_in, chan2_default_in, chan1_pin_in} <= s;
		repeat (3) @(posedge pclk);
		{chan2_alt_in, chan2_default_in, chan1_pin_in} <= 3'h0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'h1) begin
			e = exp_q.pop_front();
			chk("prdata", prdata & {24'hFFFFFF, e.m}, {24'h000000, e.d & e.m});
			chk("pslverr", pslverr, e.err);
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, ext_clk_in, sleep_in} = 5'h00;
		{chan1_pin_in, chan2_default_in, chan2_alt_in} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		presetn = 1'h0;
		void'($urandom(32'hD5C4));
		lo = 8'($urandom());
		hi = 8'($urandom());
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rd(tcb_pkg::ADDR_ALT_PIN_SELECT, 8'h00, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_PERIOD_CTRL, 8'h00, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_PERIOD_VALUE, 8'hFF, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00, 8'hFF, 1'h0);
		rd(8'h40, 8'h00, 8'hFF, 1'h1);
		wr(tcb_pkg::ADDR_PERIOD_CTRL, hi);
		rd(tcb_pkg::ADDR_PERIOD_CTRL, hi, 8'h7F, 1'h0);
		// Captures of a stopped count on both channels and pin steering
		wr(tcb_pkg::ADDR_COUNT_LOW, lo);
		wr(tcb_pkg::ADDR_COUNT_HIGH, hi);
		wr(tcb_pkg::ADDR_ALT_PIN_SELECT, 8'h03);
		wr(tcb_pkg::ADDR_CHAN2_MODE, {5'h00, tcb_pkg::MODE_COMPARE_TOGGLE});
		wt(1);
		chk("slave_select_alt", slave_select_alt, 1'h1);
		chk("chan2_alt_oe", chan2_alt_oe, 1'h1);
		chk("chan2_default_oe", chan2_default_oe, 1'h0);
		wr(tcb_pkg::ADDR_CHAN2_MODE, {5'h00, tcb_pkg::MODE_CAPTURE_RISE});
		wr(tcb_pkg::ADDR_CHAN1_MODE, {5'h00, tcb_pkg::MODE_CAPTURE_FALL});
		pulse(3'h2);
		rd(tcb_pkg::ADDR_CHAN2_LOW, 8'h00, 8'hFF, 1'h0);
		pulse(3'h5);
		rd(tcb_pkg::ADDR_CHAN2_LOW, lo, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_CHAN2_HIGH, hi, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_CHAN1_LOW, lo, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_CHAN1_HIGH, hi, 8'hFF, 1'h0);
		// Wrap from FFFDh with the rollover interrupt enabled
		wr(tcb_pkg::ADDR_COUNT_LOW, 8'hFD);
		wr(tcb_pkg::ADDR_COUNT_HIGH, 8'hFF);
		wr(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00);
		wr(tcb_pkg::ADDR_PERIPH_ENABLES, 8'h01);
		wr(tcb_pkg::ADDR_IRQ_CONTROL, 8'hC0);
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h01);
		wt(10);
		chk("irq_req", irq_req, 1'h1);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h01, 8'h01, 1'h0);
		rd(tcb_pkg::ADDR_COUNT_HIGH, 8'h00, 8'hFF, 1'h0);
		wr(tcb_pkg::ADDR_IRQ_CONTROL, 8'h80);
		wt(2);
		chk("irq_req", irq_req, 1'h0);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h01, 8'h01, 1'h0);
		wr(tcb_pkg::ADDR_IRQ_CONTROL, 8'hC0);
		wt(2);
		chk("irq_req", irq_req, 1'h1);
		wr(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00);
		wt(2);
		chk("irq_req", irq_req, 1'h0);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00, 8'h01, 1'h0);
		// Special trigger with period zero holds the count at 0000h
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h00);
		wr(tcb_pkg::ADDR_COUNT_LOW, 8'h00);
		wr(tcb_pkg::ADDR_COUNT_HIGH, 8'h00);
		wr(tcb_pkg::ADDR_CHAN1_MODE, {5'h00, tcb_pkg::MODE_COMPARE_SPECIAL});
		wr(tcb_pkg::ADDR_CHAN1_LOW, 8'h00);
		wr(tcb_pkg::ADDR_CHAN1_HIGH, 8'h00);
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h01);
		wt(20);
		pulse(3'h4);
		rd(tcb_pkg::ADDR_CHAN2_LOW, 8'h00, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_CHAN2_HIGH, 8'h00, 8'hFF, 1'h0);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h04, 8'h05, 1'h0);
		wr(tcb_pkg::ADDR_COUNT_LOW, 8'h80);
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h00);
		rd(tcb_pkg::ADDR_COUNT_LOW, 8'h80, 8'h80, 1'h0);
		rd(tcb_pkg::ADDR_COUNT_HIGH, 8'h00, 8'hFF, 1'h0);
		// Asleep: internal clock stops, external asynchronous wakes
		wr(tcb_pkg::ADDR_CHAN1_MODE, {5'h00, tcb_pkg::MODE_OFF});
		wr(tcb_pkg::ADDR_COUNT_LOW, 8'h00);
		@(posedge pclk);
		sleep_in <= 1'h1;
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h01);
		wt(20);
		rd(tcb_pkg::ADDR_COUNT_LOW, 8'h00, 8'hFF, 1'h0);
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h00);
		wr(tcb_pkg::ADDR_COUNT_LOW, 8'hFE);
		wr(tcb_pkg::ADDR_COUNT_HIGH, 8'hFF);
		wr(tcb_pkg::ADDR_COUNTER_CTRL, 8'h0F);
		repeat (4) begin
			@(posedge pclk);
			ext_clk_in <= 1'h1;
			repeat (2) @(posedge pclk);
			ext_clk_in <= 1'h0;
			@(posedge pclk);
		end
		wt(2);
		chk("wake_req", wake_req, 1'h1);
		chk("isr_branch", isr_branch, 1'h1);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h01, 8'h01, 1'h0);
		wr(tcb_pkg::ADDR_IRQ_CONTROL, 8'h40);
		wt(2);
		chk("isr_branch", isr_branch, 1'h0);
		chk("wake_req", wake_req, 1'h1);
		@(posedge pclk);
		sleep_in <= 1'h0;
		wt(2);
		// PWM on both channels from one period, then a 1:16 postscaler
		wr(tcb_pkg::ADDR_ALT_PIN_SELECT, 8'h00);
		wr(tcb_pkg::ADDR_PERIOD_VALUE, 8'h03);
		wr(tcb_pkg::ADDR_CHAN1_LOW, 8'h01);
		wr(tcb_pkg::ADDR_CHAN2_LOW, 8'h02);
		wr(tcb_pkg::ADDR_CHAN1_MODE, {5'h00, tcb_pkg::MODE_PWM});
		wr(tcb_pkg::ADDR_CHAN2_MODE, {5'h00, tcb_pkg::MODE_PWM});
		wr(tcb_pkg::ADDR_PERIOD_CTRL, 8'h04);
		wt(300);
		{lo, hi} = 16'h0000;
		repeat (8) begin
			wt(1);
			lo += chan1_pin_out;
			hi += chan2_default_out;
			chk("pwm_align", chan1_pin_out & ~chan2_default_out, 1'h0);
		end
		chk("pwm1", lo, 8'h04);
		chk("pwm2", hi, 8'h06);
		wr(tcb_pkg::ADDR_PERIOD_CTRL, 8'h7C);
		wr(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h00, 8'h02, 1'h0);
		wt(70);
		rd(tcb_pkg::ADDR_PERIPH_FLAGS, 8'h02, 8'h02, 1'h0);
		conclude();
	end
endmodule : tb

`default_nettype wire

/* verification/tcb_timebase_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module tcb_timebase_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// Core and pins
	input wire logic sleep_in,
	input wire logic chan2_default_oe,
	input wire logic chan2_alt_oe,
	input wire logic chan2_default_out,
	input wire logic chan2_alt_out,
	input wire logic irq_req,
	input wire logic wake_req,
	input wire logic isr_branch,
	input wire logic [15:0] isr_vector
);
	logic wr;
	assign wr = psel && penable && pwrite;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////
	property p_oe_excl;
		!(chan2_default_oe && chan2_alt_oe);
	endproperty
	a_oe_excl: assert property (p_oe_excl)
		else $error("channel two drives both pins");
	property p_outs_same;
		chan2_default_out == chan2_alt_out;
	endproperty
	a_outs_same: assert property (p_outs_same)
		else $error("channel two pin values differ");
	property p_alt_hi;
		wr && paddr == tcb_pkg::ADDR_ALT_PIN_SELECT && pwdata[0]
			|=> !chan2_default_oe;
	endproperty
	a_alt_hi: assert property (p_alt_hi)
		else $error("default pin driven after alternate select");
	property p_alt_lo;
		wr && paddr == tcb_pkg::ADDR_ALT_PIN_SELECT && !pwdata[0]
			|=> !chan2_alt_oe;
	endproperty
	a_alt_lo: assert property (p_alt_lo)
		else $error("alternate pin driven after default select");
	property p_vector;
		isr_vector == tcb_pkg::ISR_VECTOR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("service vector wrong");
	property p_irq_off;
		wr && paddr == tcb_pkg::ADDR_IRQ_CONTROL && !pwdata[6]
			|=> ##1 !irq_req;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt kept without peripheral enable");
	property p_branch_off;
		wr && paddr == tcb_pkg::ADDR_IRQ_CONTROL && !pwdata[7]
			|=> ##1 !isr_branch;
	endproperty
	a_branch_off: assert property (p_branch_off)
		else $error("branch kept without global enable");
	property p_wake_off;
		wr && paddr == tcb_pkg::ADDR_COUNTER_CTRL && !pwdata[0]
			|=> ##1 !wake_req;
	endproperty
	a_wake_off: assert property (p_wake_off)
		else $error("wake kept with counter stopped");
	property p_wake_sleep;
		wake_req |-> $past(sleep_in);
	endproperty
	a_wake_sleep: assert property (p_wake_sleep)
		else $error("wake request while awake");
endmodule : tcb_timebase_chk

bind tcb_timebase tcb_timebase_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleep_in(sleep_in),
	.chan2_default_oe(chan2_default_oe), .chan2_alt_oe(chan2_alt_oe),
	.chan2_default_out(chan2_default_out), .chan2_alt_out(chan2_alt_out),
	.irq_req(irq_req), .wake_req(wake_req), .isr_branch(isr_branch),
	.isr_vector(isr_vector)
);

`default_nettype wire
